// ### rtl/reject_monitor_defs.svh
// constants for the reject confirm and pack check monitor
`ifndef REJECT_MONITOR_DEFS_SVH
`define REJECT_MONITOR_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_CONTROL 12'h000
`define OFS_CONF_DELAY 12'h004
`define OFS_CONF_WINDOW 12'h008
`define OFS_CONF_TIMEOUT 12'h00C
`define OFS_CHECK_DELAY 12'h010
`define OFS_CHECK_WINDOW 12'h014
`define OFS_CHECK_TIMEOUT 12'h018
`define OFS_RELOCK_TIME 12'h01C
`define OFS_EXPECT_LEN 12'h020
`define OFS_DWELL 12'h024
`define OFS_STATUS 12'h028
`define OFS_FAULT_CLEAR 12'h02C

// ****************************************
// control fields
// ****************************************
`define CTL_CONF_EN 0
`define CTL_REG_EYE 1
`define CTL_PACK_EN 2
`define CTL_MISS_ERR 3
`define CTL_DEBUG_AUX 4
`define CTL_AIR_EN 5
`define CTL_BINLOCK_EN 6
`define CTL_DOUBLE_EN 7
`define CTL_REJ_DIS 8
`define CTL_BINFULL_EN 9
`define CTL_UNLOCK 10
`define CTL_MODE_LO 12
`define CTL_MODE_HI 14
`define CTL_RESET 32'h0000_0000

// ****************************************
// fault bits
// ****************************************
`define FLT_CONF_MISS 0
`define FLT_CONF_BLOCK 1
`define FLT_CHECK_MISS 2
`define FLT_CHECK_BLOCK 3
`define FLT_AIR 4
`define FLT_BINFULL 5
`define FLT_MISS_ERR 6
`define FLT_WIDTH 7

// ****************************************
// timing
// ****************************************
`define CLK_HZ 20000000
`define TICK_US 1000
`define TICK_CYCLES ((`CLK_HZ / 1000000) * `TICK_US)
`define AIR_MS 3000
`define AIR_TICKS (`AIR_MS * 1000 / `TICK_US)
`define RELOCK_MIN_S 5
`define RELOCK_MAX_S 30
`define RELOCK_MIN_TICKS (`RELOCK_MIN_S * 1000000 / `TICK_US)
`define RELOCK_MAX_TICKS (`RELOCK_MAX_S * 1000000 / `TICK_US)

`endif

// ### rtl/reject_monitor_pkg.sv
// types for the reject confirm and pack check monitor
package reject_monitor_pkg;
   typedef enum logic [2:0] {
      MODE_PULSE = 3'b000,
      MODE_PULSE_EXT = 3'b001,
      MODE_TOGGLE = 3'b010,
      MODE_DWELL_EXT = 3'b011,
      MODE_TILL_ACCEPT = 3'b100
   } reject_mode_t;

   typedef enum logic [1:0] {
      WIN_IDLE = 2'b00,
      WIN_DELAY = 2'b01,
      WIN_OPEN = 2'b10
   } win_state_t;
endpackage

// ### rtl/win_timer_if.sv
// carrier between the monitor and a window timer
`timescale 1ns/1ns
interface win_timer_if;
   logic start;
   logic hit;
   logic tick;
   logic [19:0] delay;
   logic [19:0] window;
   logic open;
   logic expired;
   modport owner (output start, hit, tick, delay, window,
      input open, expired);
   modport timer (input start, hit, tick, delay, window,
      output open, expired);
endinterface

// ### rtl/win_timer.sv
// delay then window timer raising a pulse if no hit arrives
`timescale 1ns/1ns
module win_timer
   import reject_monitor_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_in,
   win_timer_if.timer t
);
   win_state_t state_q;
   logic [19:0] cnt_q;
   logic expired_q;

   // ****************************************
   // sequencing
   // ****************************************
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= WIN_IDLE;
         cnt_q <= 20'h0_0000;
         expired_q <= 1'b0;
      end else begin
         expired_q <= 1'b0;
         case (state_q)
            WIN_IDLE: begin
               if (t.start) begin
                  cnt_q <= t.delay;
                  state_q <= (t.delay == 20'h0_0000) ? WIN_OPEN : WIN_DELAY;
                  if (t.delay == 20'h0_0000)
                     cnt_q <= t.window;
               end
            end
            WIN_DELAY: begin
               if (t.tick) begin
                  if (cnt_q <= 20'h0_0001) begin
                     cnt_q <= t.window;
                     state_q <= WIN_OPEN;
                  end else begin
                     cnt_q <= cnt_q - 20'h0_0001;
                  end
               end
            end
            WIN_OPEN: begin
               if (t.hit) begin
                  state_q <= WIN_IDLE;
               end else if (t.tick) begin
                  if (cnt_q <= 20'h0_0001) begin
                     expired_q <= 1'b1;
                     state_q <= WIN_IDLE;
                  end else begin
                     cnt_q <= cnt_q - 20'h0_0001;
                  end
               end
            end
            default: state_q <= WIN_IDLE;
         endcase
      end
   end

   assign t.open = (state_q == WIN_OPEN);
   assign t.expired = expired_q;
endmodule

// ### rtl/reject_monitor.sv
// supervisory timing for the reject station of an inspection conveyor
//
// Summary of operation
// - missing confirmation within window raises fault
// - no registration eye: window starts at actuation
// - registration eye: delay precedes confirmation window
// - confirmation eye blocked too long raises fault when registration eye is enabled
// - pack check stops conveyor on lost pack
// - check delay precedes pack check window
// - no pack seen within check window faults
// - pack check eye blocked too long faults
// - missing pack action forced fault unless error action set in pulse extension
// - error action reports without stopping conveyor
// - debug aux lights lamp while pack check window open
// - low air pressure over 3s faults
// - validation test releases bin lock
// - bin relocks after clamped 5 to 30s timeout
// - overlength product rejected when double bag and registration eye enabled
// - service disable suppresses reject actuator
// - pulse extension restarts dwell on second reject
// - bin full beam broken raises fault
`timescale 1ns/1ns
`include "reject_monitor_defs.svh"
module reject_monitor #(
   parameter int TICK_CYCLES = `TICK_CYCLES,
   parameter int CNT_W = 20
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic reject_fire_in,
   input wire logic reject_ok_in,
   input wire logic infeed_eye_in,
   input wire logic confirm_eye_in,
   input wire logic check_eye_in,
   input wire logic reg_eye_in,
   input wire logic air_low_in,
   input wire logic bin_full_in,
   input wire logic performance_validation_in,
   output logic actuator_out,
   output logic fault_out,
   output logic conveyor_stop_out,
   output logic error_out,
   output logic inspect_lamp_out,
   output logic bin_lock_out
);
   import reject_monitor_pkg::*;

   logic [31:0] ctl_q;
   logic [CNT_W-1:0] conf_dly_q, conf_win_q, conf_to_q;
   logic [CNT_W-1:0] chk_dly_q, chk_win_q, chk_to_q;
   logic [CNT_W-1:0] relock_q, exp_len_q, dwell_q;
   logic [`FLT_WIDTH-1:0] flt_q;
   logic [`FLT_WIDTH-1:0] flt_set;
   logic [31:0] tick_cnt_q;
   logic tick;
   logic wr_en, clr_en;
   reject_mode_t mode;

   // ****************************************
   // apb slave
   // ****************************************
   function automatic logic mapped(input logic [11:0] a);
      mapped = (a <= `OFS_FAULT_CLEAR) && (a[1:0] == 2'b00);
   endfunction

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped(paddr);
   assign wr_en = psel && penable && pwrite && mapped(paddr);
   assign clr_en = wr_en && (paddr == `OFS_FAULT_CLEAR);
   assign mode = reject_mode_t'(ctl_q[`CTL_MODE_HI:`CTL_MODE_LO]);

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         ctl_q <= `CTL_RESET;
         conf_dly_q <= '0;
         conf_win_q <= '0;
         conf_to_q <= '0;
         chk_dly_q <= '0;
         chk_win_q <= '0;
         chk_to_q <= '0;
         relock_q <= CNT_W'(`RELOCK_MIN_TICKS);
         exp_len_q <= '0;
         dwell_q <= '0;
      end else if (wr_en) begin
         case (paddr)
            `OFS_CONTROL: ctl_q <= pwdata;
            `OFS_CONF_DELAY: conf_dly_q <= pwdata[CNT_W-1:0];
            `OFS_CONF_WINDOW: conf_win_q <= pwdata[CNT_W-1:0];
            `OFS_CONF_TIMEOUT: conf_to_q <= pwdata[CNT_W-1:0];
            `OFS_CHECK_DELAY: chk_dly_q <= pwdata[CNT_W-1:0];
            `OFS_CHECK_WINDOW: chk_win_q <= pwdata[CNT_W-1:0];
            `OFS_CHECK_TIMEOUT: chk_to_q <= pwdata[CNT_W-1:0];
            `OFS_RELOCK_TIME: begin
               if (pwdata < 32'(`RELOCK_MIN_TICKS))
                  relock_q <= CNT_W'(`RELOCK_MIN_TICKS);
               else if (pwdata > 32'(`RELOCK_MAX_TICKS))
                  relock_q <= CNT_W'(`RELOCK_MAX_TICKS);
               else
                  relock_q <= pwdata[CNT_W-1:0];
            end
            `OFS_EXPECT_LEN: exp_len_q <= pwdata[CNT_W-1:0];
            `OFS_DWELL: dwell_q <= pwdata[CNT_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `OFS_CONTROL: prdata <= ctl_q;
            `OFS_CONF_DELAY: prdata <= 32'(conf_dly_q);
            `OFS_CONF_WINDOW: prdata <= 32'(conf_win_q);
            `OFS_CONF_TIMEOUT: prdata <= 32'(conf_to_q);
            `OFS_CHECK_DELAY: prdata <= 32'(chk_dly_q);
            `OFS_CHECK_WINDOW: prdata <= 32'(chk_win_q);
            `OFS_CHECK_TIMEOUT: prdata <= 32'(chk_to_q);
            `OFS_RELOCK_TIME: prdata <= 32'(relock_q);
            `OFS_EXPECT_LEN: prdata <= 32'(exp_len_q);
            `OFS_DWELL: prdata <= 32'(dwell_q);
            `OFS_STATUS: prdata <= {23'h00_0000, bin_lock_out, 1'b0,
               flt_q};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // common tick
   // ****************************************
   // shared tick
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in)
         tick_cnt_q <= 32'h0000_0000;
      else if (tick_cnt_q >= 32'(TICK_CYCLES - 1))
         tick_cnt_q <= 32'h0000_0000;
      else
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
   end
   assign tick = (tick_cnt_q == 32'h0000_0000);

   // ****************************************
   // confirmation and pack check windows
   // ****************************************
   win_timer_if conf_if ();
   win_timer_if chk_if ();
   logic fire_q, ok_q, infeed_q, chk_eye_q, conf_eye_q, reg_q;
   logic fire_rise, ok_rise, chk_rise, conf_rise;

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         fire_q <= 1'b0;
         ok_q <= 1'b0;
         infeed_q <= 1'b0;
         chk_eye_q <= 1'b0;
         conf_eye_q <= 1'b0;
         reg_q <= 1'b0;
      end else begin
         fire_q <= reject_fire_in;
         ok_q <= reject_ok_in;
         infeed_q <= infeed_eye_in;
         chk_eye_q <= check_eye_in;
         conf_eye_q <= confirm_eye_in;
         reg_q <= reg_eye_in;
      end
   end
   assign fire_rise = reject_fire_in && !fire_q;
   assign ok_rise = reject_ok_in && !ok_q;
   assign chk_rise = check_eye_in && !chk_eye_q;
   assign conf_rise = confirm_eye_in && !conf_eye_q;

   assign conf_if.start = ctl_q[`CTL_CONF_EN] && fire_rise &&
      !ctl_q[`CTL_REJ_DIS];
   assign conf_if.delay = ctl_q[`CTL_REG_EYE] ? conf_dly_q : '0;
   assign conf_if.window = conf_win_q;
   assign conf_if.hit = conf_rise;
   assign conf_if.tick = tick;

   assign chk_if.start = ctl_q[`CTL_PACK_EN] && ok_rise;
   assign chk_if.delay = chk_dly_q;
   assign chk_if.window = chk_win_q;
   assign chk_if.hit = chk_rise;
   assign chk_if.tick = tick;

   win_timer conf_timer (.mclk_in(mclk_in), .rst_in(rst_in), .t(conf_if));
   win_timer chk_timer (.mclk_in(mclk_in), .rst_in(rst_in), .t(chk_if));

   // ****************************************
   // blocked eye, air and length timers
   // ****************************************
   logic [CNT_W-1:0] conf_blk_q, chk_blk_q, air_q, len_q, dwell_cnt_q;
   logic miss_err;

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         conf_blk_q <= '0;
         chk_blk_q <= '0;
         air_q <= '0;
         len_q <= '0;
      end else begin
         if (!confirm_eye_in)
            conf_blk_q <= '0;
         else if (tick && conf_blk_q != '1)
            conf_blk_q <= conf_blk_q + 1'b1;
         if (!check_eye_in)
            chk_blk_q <= '0;
         else if (tick && chk_blk_q != '1)
            chk_blk_q <= chk_blk_q + 1'b1;
         if (!air_low_in)
            air_q <= '0;
         else if (tick && air_q != '1)
            air_q <= air_q + 1'b1;
         if (!reg_eye_in)
            len_q <= '0;
         else if (tick && len_q != '1)
            len_q <= len_q + 1'b1;
      end
   end

   assign miss_err = ctl_q[`CTL_MISS_ERR] && (mode == MODE_PULSE_EXT);

   always_comb begin
      flt_set = '0;
      flt_set[`FLT_CONF_MISS] = conf_if.expired;
      flt_set[`FLT_CONF_BLOCK] = ctl_q[`CTL_CONF_EN] &&
         ctl_q[`CTL_REG_EYE] && conf_to_q != '0 && conf_blk_q >= conf_to_q;
      flt_set[`FLT_CHECK_MISS] = chk_if.expired && !miss_err;
      flt_set[`FLT_MISS_ERR] = chk_if.expired && miss_err;
      flt_set[`FLT_CHECK_BLOCK] = ctl_q[`CTL_PACK_EN] && chk_to_q != '0 &&
         chk_blk_q >= chk_to_q;
      flt_set[`FLT_AIR] = ctl_q[`CTL_AIR_EN] &&
         air_q > CNT_W'(`AIR_TICKS);
      flt_set[`FLT_BINFULL] = ctl_q[`CTL_BINFULL_EN] && bin_full_in;
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in)
         flt_q <= '0;
      else
         flt_q <= (clr_en ? (flt_q & ~pwdata[`FLT_WIDTH-1:0]) : flt_q)
            | flt_set;
   end

   assign fault_out = |flt_q[`FLT_WIDTH-2:0];
   assign error_out = flt_q[`FLT_MISS_ERR];
   assign conveyor_stop_out = ctl_q[`CTL_PACK_EN] &&
      (flt_q[`FLT_CHECK_MISS] || flt_q[`FLT_CHECK_BLOCK]);
   assign inspect_lamp_out = ctl_q[`CTL_DEBUG_AUX] && chk_if.open;

   // ****************************************
   // actuator
   // ****************************************
   logic dbl_q;
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         dwell_cnt_q <= '0;
         dbl_q <= 1'b0;
      end else begin
         dbl_q <= ctl_q[`CTL_DOUBLE_EN] && ctl_q[`CTL_REG_EYE] &&
            exp_len_q != '0 && len_q > exp_len_q && reg_eye_in;
         if (fire_rise || (dbl_q && reg_q && !reg_eye_in))
            dwell_cnt_q <= dwell_q;
         else if (tick && dwell_cnt_q != '0)
            dwell_cnt_q <= dwell_cnt_q - 1'b1;
      end
   end
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in)
         actuator_out <= 1'b0;
      else
         actuator_out <= !ctl_q[`CTL_REJ_DIS] &&
            (dwell_cnt_q != '0 || fire_rise);
   end

   // ****************************************
   // bin lock
   // ****************************************
   logic [CNT_W-1:0] unlock_q;
   logic unlock_req;
   assign unlock_req = ctl_q[`CTL_BINLOCK_EN] &&
      ((wr_en && paddr == `OFS_CONTROL && pwdata[`CTL_UNLOCK]) ||
       performance_validation_in);
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in)
         unlock_q <= '0;
      else if (unlock_req)
         unlock_q <= relock_q;
      else if (tick && unlock_q != '0)
         unlock_q <= unlock_q - 1'b1;
   end
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in)
         bin_lock_out <= 1'b0;
      else
         bin_lock_out <= ctl_q[`CTL_BINLOCK_EN] && unlock_q == '0 &&
            !unlock_req;
   end

   logic unused_ok;
   assign unused_ok = infeed_q;
endmodule

// ### test/reject_monitor_chk.sv
// assertion checker watching the reject monitor top ports
`timescale 1ns/1ns
module reject_monitor_chk (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pslverr,
   input wire logic performance_validation_in,
   input wire logic actuator_out,
   input wire logic fault_out,
   input wire logic conveyor_stop_out,
   input wire logic error_out,
   input wire logic bin_lock_out
);
   logic clr_wr;
   logic any_wr;
   assign any_wr = psel && penable && pwrite;
   assign clr_wr = any_wr && paddr == 12'h02C;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);
   // ****************************************
   // sequences and properties
   // ****************************************
   sequence s_fault_held;
      fault_out && !clr_wr;
   endsequence
   sequence s_pv_run;
      performance_validation_in [*3];
   endsequence
   property p_fault_latch;
      s_fault_held |=> fault_out;
   endproperty
   property p_fault_clear;
      $fell(fault_out) |-> $past(clr_wr);
   endproperty
   property p_stop_fault;
      conveyor_stop_out |-> fault_out;
   endproperty
   property p_stop_latch;
      conveyor_stop_out && !any_wr |=> conveyor_stop_out;
   endproperty
   property p_err_latch;
      error_out && !clr_wr |=> error_out;
   endproperty
   property p_err_nostop;
      $rose(error_out) |-> !conveyor_stop_out;
   endproperty
   property p_pv_unlock;
      s_pv_run |-> !bin_lock_out;
   endproperty
   property p_reset_low;
      $fell(rst_in) |-> !actuator_out && !fault_out && !bin_lock_out;
   endproperty
   property p_bad_addr;
      psel && penable && paddr > 12'h02C |-> pslverr;
   endproperty
   a_fault_latch: assert property (p_fault_latch)
      else $error("fault dropped without clear");
   a_fault_clear: assert property (p_fault_clear)
      else $error("fault fell without clear write");
   a_stop_fault: assert property (p_stop_fault)
      else $error("stop without fault");
   a_stop_latch: assert property (p_stop_latch)
      else $error("stop dropped");
   a_err_latch: assert property (p_err_latch)
      else $error("error dropped without clear");
   a_err_nostop: assert property (p_err_nostop)
      else $error("missing pack error stopped conveyor");
   a_pv_unlock: assert property (p_pv_unlock)
      else $error("bin locked during validation");
   a_reset_low: assert property (p_reset_low)
      else $error("outputs not low after reset");
   a_bad_addr: assert property (p_bad_addr)
      else $error("unmapped access not refused");
endmodule
bind reject_monitor reject_monitor_chk u_chk (
   .mclk_in,
   .rst_in,
   .psel,
   .penable,
   .pwrite,
   .paddr,
   .pslverr,
   .performance_validation_in,
   .actuator_out,
   .fault_out,
   .conveyor_stop_out,
   .error_out,
   .bin_lock_out
);

// ### test/eye_model.sv
// photo-eye model: beam blocked a while after a trigger
`timescale 1ns/1ns
module eye_model #(
   parameter int LAT = 5
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic trig_in,
   input wire logic [1:0] mode_in,
   output logic eye_out
);
   logic trig_q;
   int cnt_q;
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         trig_q <= 1'b0;
         cnt_q <= 0;
      end else begin
         trig_q <= trig_in;
         if (trig_in && !trig_q && mode_in == 2'h0)
            cnt_q <= LAT + 3;
         else if (cnt_q > 0)
            cnt_q <= cnt_q - 1;
      end
   end
   // mode 1 silent, mode 2 stuck blocked
   assign eye_out = mode_in == 2'h2 || (cnt_q > 0 && cnt_q <= 3);
endmodule

// ### test/reject_monitor_test.sv
// self-checking bench for the reject monitor
`timescale 1ns/1ns
`include "reject_monitor_defs.svh"
module reject_monitor_test;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic serr;
   logic fire = 1'b0;
   logic ok = 1'b0;
   logic air = 1'b0;
   logic binf = 1'b0;
   logic pv = 1'b0;
   logic reg_eye = 1'b0;
   logic infeed = 1'b0;
   logic [1:0] cm = 2'h0;
   logic [1:0] km = 2'h0;
   logic ceye, keye, act, flt, stp, err, lamp, lock;
   int failures = 0;
   int checked = 0;
   always #25 mclk_in = ~mclk_in;
   reject_monitor #(.TICK_CYCLES(10)) u_dut (
      .mclk_in(mclk_in), .rst_in(rst_in), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .reject_fire_in(fire), .reject_ok_in(ok),
      .infeed_eye_in(infeed), .confirm_eye_in(ceye),
      .check_eye_in(keye), .reg_eye_in(reg_eye), .air_low_in(air),
      .bin_full_in(binf), .performance_validation_in(pv),
      .actuator_out(act), .fault_out(flt), .conveyor_stop_out(stp),
      .error_out(err), .inspect_lamp_out(lamp), .bin_lock_out(lock));
   eye_model #(.LAT(5)) u_ceye (.mclk_in(mclk_in), .rst_in(rst_in),
      .trig_in(act), .mode_in(cm), .eye_out(ceye));
   eye_model #(.LAT(30)) u_keye (.mclk_in(mclk_in), .rst_in(rst_in),
      .trig_in(ok), .mode_in(km), .eye_out(keye));
   // ****************************************
   // helpers
   // ****************************************
   task automatic give_verdict;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      cyc(1);
      penable <= 1'b1;
      cyc(1);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         cyc(1);
      end
      if (n == 20) begin
         failures++;
         give_verdict();
      end
      r = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      cyc(1);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      apb(1'b0, a, 32'h0000_0000, r);
      chk("read", e, r);
   endtask
   task automatic st(input logic [31:0] e);
      logic [31:0] r;
      apb(1'b0, `OFS_STATUS, 32'h0000_0000, r);
      chk("status", e, r & 32'h0000_007F);
   endtask
   task automatic cfg(input logic [31:0] c);
      wr(`OFS_FAULT_CLEAR, 32'h0000_007F);
      wr(`OFS_CONTROL, c);
   endtask
   task automatic pulse(input logic f);
      if (f)
         fire <= 1'b1;
      else
         ok <= 1'b1;
      cyc(3);
      fire <= 1'b0;
      ok <= 1'b0;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs;
      rdc(`OFS_CONTROL, `CTL_RESET);
      rdc(`OFS_RELOCK_TIME, 32'h0000_1388);
      wr(`OFS_RELOCK_TIME, 32'h0000_0001);
      rdc(`OFS_RELOCK_TIME, 32'h0000_1388);
      wr(`OFS_RELOCK_TIME, 32'h0000_9C40);
      rdc(`OFS_RELOCK_TIME, 32'h0000_7530);
      rdc(12'h030, 32'h0000_0000);
      chk("pslverr", 32'h0000_0001, {31'h0, serr});
   endtask
   task automatic t_conf;
      wr(`OFS_DWELL, 32'h0000_0005);
      wr(`OFS_CONF_WINDOW, 32'h0000_0003);
      cfg(32'h0000_0001);
      pulse(1'b1);
      cyc(100);
      st(32'h0000_0000);
      cm <= 2'h1;
      pulse(1'b1);
      cyc(100);
      st(32'h0000_0001);
      chk("fault", 32'h0000_0001, {31'h0, flt});
      cm <= 2'h2;
      wr(`OFS_CONF_TIMEOUT, 32'h0000_0002);
      cfg(32'h0000_0003);
      cyc(60);
      st(32'h0000_0002);
      cm <= 2'h0;
   endtask
   task automatic t_pack;
      wr(`OFS_CHECK_WINDOW, 32'h0000_0005);
      wr(`OFS_CHECK_DELAY, 32'h0000_0002);
      cfg(32'h0000_0004);
      pulse(1'b0);
      cyc(120);
      st(32'h0000_0000);
      wr(`OFS_CHECK_DELAY, 32'h0000_0006);
      pulse(1'b0);
      cyc(150);
      st(32'h0000_0004);
      chk("stop", 32'h0000_0001, {31'h0, stp});
      km <= 2'h2;
      wr(`OFS_CHECK_TIMEOUT, 32'h0000_0002);
      cfg(32'h0000_0004);
      cyc(60);
      st(32'h0000_0008);
      km <= 2'h1;
   endtask
   task automatic t_miss;
      wr(`OFS_CHECK_DELAY, 32'h0000_0000);
      cfg(32'h0000_100C);
      pulse(1'b0);
      cyc(100);
      st(32'h0000_0040);
      chk("stop", 32'h0000_0000, {31'h0, stp});
      chk("error", 32'h0000_0001, {31'h0, err});
      cfg(32'h0000_000C);
      pulse(1'b0);
      cyc(100);
      st(32'h0000_0004);
   endtask
   task automatic t_lamp;
      int len;
      len = 0;
      wr(`OFS_CHECK_DELAY, 32'h0000_0002);
      wr(`OFS_CHECK_WINDOW, 32'h0000_0004);
      cfg(32'h0000_0014);
      pulse(1'b0);
      repeat (150) begin
         cyc(1);
         if (lamp === 1'b1)
            len++;
      end
      chk("lamp", 32'h0000_0001, {31'h0, len >= 30 && len <= 41});
   endtask
   task automatic t_dis;
      int seen;
      seen = 0;
      cfg(32'h0000_0100);
      pulse(1'b1);
      repeat (40) begin
         cyc(1);
         if (act === 1'b1)
            seen = 1;
      end
      chk("actuator", 32'h0000_0000, seen);
   endtask
   task automatic t_dwell;
      cfg(32'h0000_1000);
      pulse(1'b1);
      cyc(27);
      pulse(1'b1);
      cyc(27);
      chk("dwell on", 32'h0000_0001, {31'h0, act});
      cyc(40);
      chk("dwell off", 32'h0000_0000, {31'h0, act});
      wr(`OFS_EXPECT_LEN, 32'h0000_0002);
      cfg(32'h0000_0082);
      reg_eye <= 1'b1;
      cyc(40);
      reg_eye <= 1'b0;
      cyc(3);
      chk("overlength", 32'h0000_0001, {31'h0, act});
   endtask
   task automatic t_plant;
      cfg(32'h0000_0260);
      binf <= 1'b1;
      cyc(10);
      st(32'h0000_0020);
      chk("lock", 32'h0000_0001, {31'h0, lock});
      binf <= 1'b0;
      pv <= 1'b1;
      cyc(10);
      chk("lock", 32'h0000_0000, {31'h0, lock});
      pv <= 1'b0;
      cfg(32'h0000_0020);
      air <= 1'b1;
      cyc(29000);
      chk("fault", 32'h0000_0000, {31'h0, flt});
      cyc(2000);
      st(32'h0000_0010);
      air <= 1'b0;
   endtask
   initial begin
      cyc(3);
      rst_in <= 1'b0;
      cyc(1);
      t_regs();
      t_conf();
      t_pack();
      t_miss();
      t_lamp();
      t_dis();
      t_dwell();
      t_plant();
      give_verdict();
   end
endmodule
